// File: dlk_pkg.sv
// Package for the debug lockout and debug register bank: constants and carriers
package dlk_pkg;

  // Debug register byte addresses in the 64-Kbyte space
  localparam logic [15:0] DLK_ADDR_INSTR    = 16'hFF00;
  localparam logic [15:0] DLK_ADDR_STATUS   = 16'hFF01;
  localparam logic [15:0] DLK_ADDR_SHIFT_HI = 16'hFF02;
  localparam logic [15:0] DLK_ADDR_SHIFT_LO = 16'hFF03;
  localparam logic [15:0] DLK_ADDR_ADDR_HI  = 16'hFF04;
  localparam logic [15:0] DLK_ADDR_ADDR_LO  = 16'hFF05;
  localparam logic [15:0] DLK_ADDR_CCR_HOLD = 16'hFF06;

  // Shadow word location while visible
  localparam logic [15:0] DLK_ADDR_SHADOW_HI = 16'h0FC0;
  localparam logic [15:0] DLK_ADDR_SHADOW_LO = 16'h0FC1;

  // Status register field positions
  localparam int DLK_ST_PERMIT  = 7;
  localparam int DLK_ST_ACTIVE  = 6;
  localparam int DLK_ST_TAG     = 5;
  localparam int DLK_ST_SVALID  = 4;
  localparam int DLK_ST_TRACE   = 3;
  localparam int DLK_ST_CLKSEL  = 2;

  // Hardware/firmware flag position in the instruction register
  localparam int DLK_INSTR_HWFW = 7;

  // Lockout-off bit position inside the shadow high byte
  localparam int DLK_SHADOW_LOCK_BIT = 7;

  // Status bits that any write may change
  localparam logic [7:0] DLK_ST_FREE_MASK = 8'hB8;

  // Values after reset
  localparam logic [7:0]  DLK_RST_STATUS = 8'h00;
  localparam logic [7:0]  DLK_RST_BYTE   = 8'h00;
  localparam logic [15:0] DLK_RST_WORD   = 16'h0000;

  // Cycles held after reset before the shadow byte and mode pins are trusted
  localparam logic [2:0] DLK_LOAD_CYCLES = 3'h4;

  // Reset level of a synchronised pin: mode select idles high
  localparam logic DLK_PIN_IDLE = 1'b1;

  // Block phase after reset
  typedef enum logic [0:0] {
    DLK_LOAD,
    DLK_RUN
  } dlk_phase_e;

  // Debug-space access from the serial hardware
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } dlk_dbg_req_s;

  // Shadow word program or erase request from the EEPROM controller
  typedef struct packed {
    logic        prog;
    logic        erase;
    logic [15:0] addr;
    logic [7:0]  data;
  } dlk_nv_req_s;

  // Command passed on to the nonvolatile array
  typedef struct packed {
    logic       prog;
    logic       erase;
    logic [7:0] data;
  } dlk_nv_cmd_s;

  // Synchroniser state
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } dlk_sync_s;

  // Main block state
  typedef struct packed {
    dlk_phase_e  phase;
    logic [2:0]  load_cnt;
    logic        lockout_off;
    logic [7:0]  instr;
    logic [7:0]  status;
    logic [15:0] shift;
    logic [15:0] addr_tmp;
    logic [7:0]  ccr_hold;
    logic [7:0]  rdata;
    logic        ack;
    dlk_nv_cmd_s nv_cmd;
    logic        reset_vec_ok;
  } dlk_state_s;

endpackage : dlk_pkg

// File: dlk_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module dlk_pin_sync
  import dlk_pkg::*;
(
  input  wire logic clk,    // Bus clock
  input  wire logic srst,   // Synchronous reset
  input  wire logic pin_in, // Asynchronous pin level
  output logic      level   // Filtered level
);

  dlk_sync_s st_ff;
  dlk_sync_s nxt_st;

  // First stage feeds only the second; output follows once stages 2 and 3 agree
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = pin_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    if (st_ff.s2 == st_ff.s3) begin
      nxt_st.q = st_ff.s3;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '{s1: DLK_PIN_IDLE, s2: DLK_PIN_IDLE, s3: DLK_PIN_IDLE, q: DLK_PIN_IDLE};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level = st_ff.q;

endmodule : dlk_pin_sync
`default_nettype wire

// File: dlk_debug_lockout.sv
// Debug lockout control and the background debug register bank
`timescale 1ns/1ns
`default_nettype none
module dlk_debug_lockout
  import dlk_pkg::*;
(
  input  wire logic         clk,                   // Bus clock, 100 MHz
  input  wire logic         srst,                  // Synchronous system reset
  input  wire logic         special_mode_select_n, // Mode pin, low in special modes
  input  wire logic         single_chip_pin,       // Mode pin, high for single chip
  input  wire logic [7:0]   shadow_word_hi,        // Shadow high byte from the array
  input  wire logic         shadow_protect,        // Shadow write protect bit
  input  wire logic         shadow_hide,           // Shadow hide bit
  input  wire dlk_nv_req_s  nv_req,                // Shadow program or erase request
  input  wire dlk_dbg_req_s dbg_req,               // Debug-space read or write
  input  wire logic         instr_load,            // Serial decoder loads instruction
  input  wire logic [7:0]   instr_value,           // Decoded instruction byte
  input  wire logic         shift_load,            // Serial shift completed
  input  wire logic [15:0]  shift_value,           // Word shifted in
  input  wire logic         addr_load,             // Command address received
  input  wire logic [15:0]  addr_value,            // Address word
  input  wire logic         enter_req,             // Request to enter active debug
  input  wire logic         tag_go,                // Tagging go command
  input  wire logic         trace_req,             // Trace one instruction command
  input  wire logic         ccr_save,              // Processor saves condition codes
  input  wire logic [7:0]   ccr_value,             // Condition codes to save
  output logic [7:0]        dbg_rdata,             // Read data
  output logic              dbg_ack,               // Access done, one cycle
  output logic              debug_lockout_off,     // One when debug is usable
  output logic              debug_map_active,      // Debug registers in map
  output logic              clock_source_select,   // One selects bus E clock
  output logic              shadow_visible,        // Shadow word mapped at 0FC0
  output dlk_nv_cmd_s       nv_cmd,                // Program or erase to the array
  output logic              reset_vector_ok,       // Reset vector fetch allowed
  output logic [7:0]        debug_status,          // Status register contents
  output logic [7:0]        cond_code_holding      // Saved condition codes
);

  logic smode_n_sync;
  logic single_sync;
  logic special_mode;
  logic special_single;
  logic dbg_hit;
  logic [7:0] rd_mux;
  logic [7:0] st_wr;
  logic wr_hwfw;
  logic shadow_addr_hit;
  logic shadow_open;
  logic prog_ok;
  logic erase_ok;
  logic host_wr;
  logic wr_instr;
  logic wr_status;
  logic wr_shift_hi;
  logic wr_shift_lo;
  logic wr_addr_hi;
  logic wr_addr_lo;
  logic wr_ccr;

  dlk_state_s st_ff;
  dlk_state_s nxt_st;

  // Mode pins come from outside the clock domain
  dlk_pin_sync u_sync_smode (
    .clk    (clk),
    .srst   (srst),
    .pin_in (special_mode_select_n),
    .level  (smode_n_sync)
  );

  dlk_pin_sync u_sync_single (
    .clk    (clk),
    .srst   (srst),
    .pin_in (single_chip_pin),
    .level  (single_sync)
  );

  // Mode decode
  assign special_mode   = ~smode_n_sync;
  assign special_single = special_mode & single_sync;

  // Shadow word access qualifiers; protect and hide both guard against a stray write
  always_comb begin
    shadow_addr_hit = (nv_req.addr == DLK_ADDR_SHADOW_HI) || (nv_req.addr == DLK_ADDR_SHADOW_LO);
    shadow_open     = special_mode & ~shadow_protect & ~shadow_hide;
    // Only the high byte carries lockout state
    prog_ok         = nv_req.prog & shadow_open & (nv_req.addr == DLK_ADDR_SHADOW_HI);
    // Refused in special single chip so a locked part cannot unlock itself
    erase_ok        = nv_req.erase & shadow_open & ~special_single & shadow_addr_hit;
  end

  // Readback mux; unmapped addresses return zero
  always_comb begin
    dbg_hit = 1'b1;
    if (dbg_req.addr == DLK_ADDR_INSTR) begin
      rd_mux = st_ff.instr;
    end else if (dbg_req.addr == DLK_ADDR_STATUS) begin
      rd_mux = st_ff.status;
    end else if (dbg_req.addr == DLK_ADDR_SHIFT_HI) begin
      rd_mux = st_ff.shift[15:8];
    end else if (dbg_req.addr == DLK_ADDR_SHIFT_LO) begin
      rd_mux = st_ff.shift[7:0];
    end else if (dbg_req.addr == DLK_ADDR_ADDR_HI) begin
      rd_mux = st_ff.addr_tmp[15:8];
    end else if (dbg_req.addr == DLK_ADDR_ADDR_LO) begin
      rd_mux = st_ff.addr_tmp[7:0];
    end else if (dbg_req.addr == DLK_ADDR_CCR_HOLD) begin
      rd_mux = st_ff.ccr_hold;
    end else begin
      rd_mux  = DLK_RST_BYTE;
      dbg_hit = 1'b0;
    end
  end

  // Host write strobes; an unmapped address raises none, so that write is dropped
  always_comb begin
    host_wr     = dbg_req.valid & dbg_req.write & dbg_hit;
    wr_instr    = 1'b0;
    wr_status   = 1'b0;
    wr_shift_hi = 1'b0;
    wr_shift_lo = 1'b0;
    wr_addr_hi  = 1'b0;
    wr_addr_lo  = 1'b0;
    wr_ccr      = 1'b0;
    if (host_wr) begin
      if (dbg_req.addr == DLK_ADDR_INSTR) begin
        wr_instr = 1'b1;
      end else if (dbg_req.addr == DLK_ADDR_STATUS) begin
        wr_status = 1'b1;
      end else if (dbg_req.addr == DLK_ADDR_SHIFT_HI) begin
        wr_shift_hi = 1'b1;
      end else if (dbg_req.addr == DLK_ADDR_SHIFT_LO) begin
        wr_shift_lo = 1'b1;
      end else if (dbg_req.addr == DLK_ADDR_ADDR_HI) begin
        wr_addr_hi = 1'b1;
      end else if (dbg_req.addr == DLK_ADDR_ADDR_LO) begin
        wr_addr_lo = 1'b1;
      end else begin
        wr_ccr = 1'b1;
      end
    end
  end

  // Status write merge: free bits always, active and clock select gated by the flag
  always_comb begin
    wr_hwfw = st_ff.instr[DLK_INSTR_HWFW];
    st_wr   = (st_ff.status & ~DLK_ST_FREE_MASK) | (dbg_req.wdata & DLK_ST_FREE_MASK);
    if (!wr_hwfw) begin
      st_wr[DLK_ST_ACTIVE] = dbg_req.wdata[DLK_ST_ACTIVE];
    end
    if (wr_hwfw) begin
      st_wr[DLK_ST_CLKSEL] = dbg_req.wdata[DLK_ST_CLKSEL];
    end
    st_wr[1:0] = 2'h0;
  end

  // Next state
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.ack    = 1'b0;
    nxt_st.nv_cmd = '0;
    case (st_ff.phase)
      DLK_LOAD: begin
        // Wait for the mode synchronisers to settle before latching strap state
        if (st_ff.load_cnt == DLK_LOAD_CYCLES) begin
          nxt_st.phase       = DLK_RUN;
          nxt_st.lockout_off = shadow_word_hi[DLK_SHADOW_LOCK_BIT];
          // Firmware permits debug in special single chip
          if (special_single && shadow_word_hi[DLK_SHADOW_LOCK_BIT]) begin
            nxt_st.status[DLK_ST_PERMIT] = 1'b1;
          end
          // Armed lockout blocks reset vector fetch in special single chip
          nxt_st.reset_vec_ok = ~(special_single & ~shadow_word_hi[DLK_SHADOW_LOCK_BIT]);
        end else begin
          nxt_st.load_cnt = st_ff.load_cnt + 3'h1;
        end
      end
      DLK_RUN: begin
        // Shadow programming only in special modes, unprotected and visible
        if (prog_ok) begin
          nxt_st.nv_cmd.prog = 1'b1;
          nxt_st.nv_cmd.data = nv_req.data;
        end
        // Erase removes lockout; refused in special single chip
        if (erase_ok) begin
          nxt_st.nv_cmd.erase = 1'b1;
        end
        // Serial hardware loads
        if (instr_load) begin
          nxt_st.instr = instr_value;
        end
        if (shift_load) begin
          nxt_st.shift = shift_value;
        end
        if (addr_load) begin
          nxt_st.addr_tmp = addr_value;
        end
        if (ccr_save) begin
          nxt_st.ccr_hold = ccr_value;
        end
        // Host debug-space access; a host write wins over a same-cycle data load
        if (dbg_req.valid) begin
          nxt_st.ack   = 1'b1;
          nxt_st.rdata = dbg_req.write ? DLK_RST_BYTE : rd_mux;
        end
        if (wr_instr) begin
          nxt_st.instr = dbg_req.wdata;
        end
        if (wr_status) begin
          nxt_st.status = st_wr;
        end
        if (wr_shift_hi) begin
          nxt_st.shift[15:8] = dbg_req.wdata;
        end
        if (wr_shift_lo) begin
          nxt_st.shift[7:0] = dbg_req.wdata;
        end
        if (wr_addr_hi) begin
          nxt_st.addr_tmp[15:8] = dbg_req.wdata;
        end
        if (wr_addr_lo) begin
          nxt_st.addr_tmp[7:0] = dbg_req.wdata;
        end
        if (wr_ccr) begin
          nxt_st.ccr_hold = dbg_req.wdata;
        end
        // Hardware flag sets come after the host write: a set and a clear in one
        // cycle leave the flag set, so a shift finishing under a status write is kept
        if (shift_load) begin
          nxt_st.status[DLK_ST_SVALID] = 1'b1;
        end
        // Tagging and trace are firmware features, dead while the lockout is armed
        if (tag_go && st_ff.lockout_off) begin
          nxt_st.status[DLK_ST_TAG] = 1'b1;
        end
        if (trace_req && st_ff.lockout_off) begin
          nxt_st.status[DLK_ST_TRACE] = 1'b1;
        end
        // Entry needs permit and no lockout; it clears tagging and beats a clear
        if (enter_req && st_ff.status[DLK_ST_PERMIT] && st_ff.lockout_off) begin
          nxt_st.status[DLK_ST_ACTIVE] = 1'b1;
          nxt_st.status[DLK_ST_TAG]    = 1'b0;
        end
        // Lockout forces the active bit low whatever was written
        if (!st_ff.lockout_off) begin
          nxt_st.status[DLK_ST_ACTIVE] = 1'b0;
        end
      end
      default: begin
        nxt_st.phase = DLK_LOAD;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff.phase        <= DLK_LOAD;
      st_ff.load_cnt     <= 3'h0;
      st_ff.lockout_off  <= 1'b0;
      st_ff.instr        <= DLK_RST_BYTE;
      st_ff.status       <= DLK_RST_STATUS;
      st_ff.shift        <= DLK_RST_WORD;
      st_ff.addr_tmp     <= DLK_RST_WORD;
      st_ff.ccr_hold     <= DLK_RST_BYTE;
      st_ff.rdata        <= DLK_RST_BYTE;
      st_ff.ack          <= 1'b0;
      st_ff.nv_cmd       <= '0;
      st_ff.reset_vec_ok <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Visibility follows the hide bit directly; registered to keep outputs clean
  logic shadow_vis_ff;
  always_ff @(posedge clk) begin
    if (srst) begin
      shadow_vis_ff <= 1'b0;
    end else begin
      shadow_vis_ff <= ~shadow_hide;
    end
  end

  // Outputs straight from state flops
  assign dbg_rdata           = st_ff.rdata;
  assign dbg_ack             = st_ff.ack;
  assign debug_lockout_off   = st_ff.lockout_off;
  assign debug_map_active    = st_ff.status[DLK_ST_ACTIVE];
  assign clock_source_select = st_ff.status[DLK_ST_CLKSEL];
  assign shadow_visible      = shadow_vis_ff;
  assign nv_cmd              = st_ff.nv_cmd;
  assign reset_vector_ok     = st_ff.reset_vec_ok;
  assign debug_status        = st_ff.status;
  assign cond_code_holding   = st_ff.ccr_hold;

endmodule : dlk_debug_lockout
`default_nettype wire

// File: dlk_chk.sv
// Port assertions for the debug lockout block
`timescale 1ns/1ns
`default_nettype none
module dlk_chk
  import dlk_pkg::*;
(
  input wire logic         clk,                   // Bus clock
  input wire logic         srst,                  // Reset
  input wire logic         special_mode_select_n, // Mode pin
  input wire logic         single_chip_pin,       // Mode pin
  input wire logic         shadow_protect,        // Protect bit
  input wire logic         shadow_hide,           // Hide bit
  input wire dlk_nv_req_s  nv_req,                // Shadow request
  input wire dlk_dbg_req_s dbg_req,               // Debug access
  input wire logic         dbg_ack,               // Access done
  input wire logic         debug_lockout_off,     // Debug usable
  input wire logic         debug_map_active,      // Map flag
  input wire logic         clock_source_select,   // Clock select
  input wire logic         shadow_visible,        // Shadow mapped
  input wire dlk_nv_cmd_s  nv_cmd,                // Array command
  input wire logic         reset_vector_ok,       // Vector allowed
  input wire logic [7:0]   debug_status           // Status
);
  logic [3:0] cnt_ff;
  logic       prog_ok_ff;
  logic       erase_ok_ff;
  logic       run;
  // Run margin covers load phase and pin sync latency
  always_ff @(posedge clk) begin
    if (srst) cnt_ff <= 4'h0;
    else if (cnt_ff != 4'hF) cnt_ff <= cnt_ff + 4'h1;
    prog_ok_ff  <= nv_req.prog && nv_req.addr == DLK_ADDR_SHADOW_HI && !shadow_protect && !shadow_hide
                   && !special_mode_select_n;
    erase_ok_ff <= nv_req.erase && (nv_req.addr == DLK_ADDR_SHADOW_HI || nv_req.addr == DLK_ADDR_SHADOW_LO)
                   && !shadow_protect && !shadow_hide && !special_mode_select_n && !single_chip_pin;
  end
  assign run = cnt_ff > 4'h7;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_ack_next: assert property (run && dbg_req.valid |=> dbg_ack) else $error("access not answered");
  a_ack_cause: assert property (dbg_ack |-> $past(dbg_req.valid)) else $error("ack without access");
  a_unused_low: assert property (debug_status[1:0] == 2'h0) else $error("unused status bits set");
  a_map_mirror: assert property (debug_map_active == debug_status[DLK_ST_ACTIVE]
    && clock_source_select == debug_status[DLK_ST_CLKSEL]) else $error("status outputs disagree");
  a_lock_idle: assert property (!debug_lockout_off |-> !debug_status[DLK_ST_ACTIVE]) else $error("active locked");
  a_prog_cause: assert property (nv_cmd.prog |-> prog_ok_ff) else $error("program not allowed");
  a_prog_taken: assert property (run && prog_ok_ff |-> nv_cmd.prog) else $error("program dropped");
  a_prog_data: assert property (nv_cmd.prog |-> nv_cmd.data == $past(nv_req.data)) else $error("bad data");
  a_erase_cause: assert property (nv_cmd.erase |-> erase_ok_ff) else $error("erase not allowed");
  a_vis_follow: assert property (run |-> shadow_visible == !$past(shadow_hide)) else $error("bad visibility");
  a_lock_steady: assert property (run |-> $stable(debug_lockout_off) && $stable(reset_vector_ok))
    else $error("lockout moved after load");
endmodule : dlk_chk
bind dlk_debug_lockout dlk_chk u_chk (.clk, .srst, .special_mode_select_n, .single_chip_pin, .shadow_protect,
  .shadow_hide, .nv_req, .dbg_req, .dbg_ack, .debug_lockout_off, .debug_map_active, .clock_source_select,
  .shadow_visible, .nv_cmd, .reset_vector_ok, .debug_status);
`default_nettype wire

// File: dlk_host.sv
// Debug host model issuing debug-space reads and writes
`timescale 1ns/1ns
`default_nettype none
module dlk_host
  import dlk_pkg::*;
(
  input  wire logic    clk,     // Bus clock
  input  wire logic    dbg_ack, // Access done
  output dlk_dbg_req_s dbg_req  // Access to block
);
  initial dbg_req = '0;
  // One access as a single valid pulse; slow adds idle cycles first
  task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d, input int slow);
    int n;
    @(posedge clk);
    repeat (slow) @(posedge clk);
    #1 dbg_req = '{1'h1, wr, a, d};
    @(posedge clk);
    #1 dbg_req.valid = 1'h0;
    // Released lines do not keep the old value
    dbg_req.addr = ~a;
    dbg_req.wdata = ~d;
    n = 0;
    while (dbg_ack !== 1'h1 && n < 4) begin
      @(posedge clk);
      n++;
    end
  endtask : access
endmodule : dlk_host
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the debug lockout block
`timescale 1ns/1ns
`default_nettype none
module testbench
  import dlk_pkg::*;
;
  logic        clk = 1'h0, srst = 1'h1, special_mode_select_n = 1'h1, single_chip_pin = 1'h0;
  logic        shadow_protect = 1'h1, shadow_hide = 1'h1, instr_load = 1'h0, shift_load = 1'h0;
  logic        addr_load = 1'h0, enter_req = 1'h0, tag_go = 1'h0, trace_req = 1'h0, ccr_save = 1'h0;
  logic [7:0]  shadow_word_hi = 8'hFF, instr_value = 8'h00, ccr_value = 8'h00, st, d, e;
  logic [15:0] shift_value = 16'h0000, addr_value = 16'h0000;
  logic        dbg_ack, debug_lockout_off, debug_map_active, clock_source_select, shadow_visible;
  logic        reset_vector_ok;
  logic [7:0]  dbg_rdata, debug_status, cond_code_holding;
  logic [7:0]  exp_q[$];
  dlk_nv_req_s  nv_req = '0;
  dlk_dbg_req_s dbg_req;
  dlk_nv_cmd_s  nv_cmd;
  int          fail_count = 0, tests_run = 0, cyc = 0;
  dlk_debug_lockout dut (.clk, .srst, .special_mode_select_n, .single_chip_pin, .shadow_word_hi, .shadow_protect,
    .shadow_hide, .nv_req, .dbg_req, .instr_load, .instr_value, .shift_load, .shift_value, .addr_load,
    .addr_value, .enter_req, .tag_go, .trace_req, .ccr_save, .ccr_value, .dbg_rdata, .dbg_ack,
    .debug_lockout_off, .debug_map_active, .clock_source_select, .shadow_visible, .nv_cmd, .reset_vector_ok,
    .debug_status, .cond_code_holding);
  dlk_host u_host (.clk, .dbg_ack, .dbg_req);
  always #5 clk = ~clk;
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    tests_run++;
    if (got !== want) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end
  // Each ack retires the oldest noted read value; mid-cycle, away from the edge
  always @(negedge clk) if (dbg_ack === 1'h1) chk(dbg_rdata, exp_q.pop_front());
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic rd(input logic [15:0] a, input logic [7:0] want);
    exp_q.push_back(want);
    u_host.access(1'h0, a, 8'h00, $urandom_range(2));
  endtask : rd
  // Writes answer with zero data
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    exp_q.push_back(8'h00);
    u_host.access(1'h1, a, v, 0);
  endtask : wr
  task automatic pulse_instr(input logic h);
    instr_load = 1'h1;
    instr_value = {h, 7'h00};
    tick(1);
    instr_load = 1'h0;
  endtask : pulse_instr
  task automatic enter;
    enter_req = 1'h1;
    tick(1);
    enter_req = 1'h0;
  endtask : enter
  task automatic nv(input logic pr, er, input logic [15:0] a, input logic p, h, ep, ee);
    shadow_protect = p;
    shadow_hide = h;
    tick(1);
    nv_req = '{pr, er, a, 8'h7F};
    tick(1);
    nv_req = '0;
    chk({nv_cmd.prog, nv_cmd.erase, shadow_visible}, {ep, ee, !h});
    if (ep) chk(nv_cmd.data, 8'h7F);
  endtask : nv
  // Mode pins and shadow byte settle during a 10-cycle reset
  task automatic boot(input logic smn, sc, input logic [7:0] sh);
    srst = 1'h1;
    special_mode_select_n = smn;
    single_chip_pin = sc;
    shadow_word_hi = sh;
    tick(10);
    srst = 1'h0;
    tick(8);
    st = (sc && !smn && sh[7]) ? 8'h80 : 8'h00;
    chk({debug_lockout_off, reset_vector_ok, debug_status}, {sh[7], !(sc && !smn && !sh[7]), st});
  endtask : boot
  initial begin
    void'($urandom(32'h2D06F26C));
    boot(1'h1, 1'h0, 8'hFF);
    rd(DLK_ADDR_STATUS, 8'h00);
    rd(16'hFF07, 8'h00);
    // Both flag settings: all ones, random, then clearing
    for (int i = 0; i < 8; i++) begin
      d = (i < 2) ? 8'hFF : (i > 5) ? 8'h00 : 8'($urandom);
      pulse_instr(i[0]);
      e = (d & DLK_ST_FREE_MASK) | (i[0] ? (st & 8'h40) | (d & 8'h04) : (d & 8'h40) | (st & 8'h04));
      wr(DLK_ADDR_STATUS, d);
      rd(DLK_ADDR_STATUS, e);
      chk({debug_map_active, clock_source_select}, {e[6], e[2]});
      st = e;
    end
    shift_value = 16'($urandom);
    addr_value = 16'($urandom);
    ccr_value = 8'($urandom);
    {shift_load, addr_load, ccr_save} = 3'h7;
    tick(1);
    {shift_load, addr_load, ccr_save} = 3'h0;
    rd(DLK_ADDR_SHIFT_HI, shift_value[15:8]);
    rd(DLK_ADDR_SHIFT_LO, shift_value[7:0]);
    rd(DLK_ADDR_ADDR_HI, addr_value[15:8]);
    rd(DLK_ADDR_ADDR_LO, addr_value[7:0]);
    rd(DLK_ADDR_CCR_HOLD, ccr_value);
    rd(DLK_ADDR_STATUS, 8'h10);
    wr(DLK_ADDR_CCR_HOLD, ~ccr_value);
    chk(cond_code_holding, {8'h00, ~ccr_value});
    // Entry refused until permit is set
    wr(DLK_ADDR_STATUS, 8'h00);
    enter();
    rd(DLK_ADDR_STATUS, 8'h00);
    wr(DLK_ADDR_STATUS, 8'h80);
    enter();
    {tag_go, trace_req} = 2'h3;
    tick(1);
    {tag_go, trace_req} = 2'h0;
    rd(DLK_ADDR_STATUS, 8'hE8);
    // Shadow program and erase in special expanded mode
    boot(1'h0, 1'h0, 8'hFF);
    nv(1'h1, 1'h0, DLK_ADDR_SHADOW_HI, 1'h0, 1'h0, 1'h1, 1'h0);
    nv(1'h1, 1'h0, DLK_ADDR_SHADOW_LO, 1'h0, 1'h0, 1'h0, 1'h0);
    nv(1'h1, 1'h0, DLK_ADDR_SHADOW_HI, 1'h1, 1'h0, 1'h0, 1'h0);
    nv(1'h1, 1'h0, DLK_ADDR_SHADOW_HI, 1'h0, 1'h1, 1'h0, 1'h0);
    nv(1'h0, 1'h1, DLK_ADDR_SHADOW_LO, 1'h0, 1'h0, 1'h0, 1'h1);
    // Armed lockout in special single chip
    boot(1'h0, 1'h1, 8'h7F);
    nv(1'h0, 1'h1, DLK_ADDR_SHADOW_HI, 1'h0, 1'h0, 1'h0, 1'h0);
    nv(1'h1, 1'h0, DLK_ADDR_SHADOW_HI, 1'h0, 1'h0, 1'h1, 1'h0);
    wr(DLK_ADDR_STATUS, 8'hC0);
    enter();
    rd(DLK_ADDR_STATUS, 8'h80);
    boot(1'h0, 1'h1, 8'hFF);
    boot(1'h1, 1'h0, 8'hFF);
    nv(1'h1, 1'h0, DLK_ADDR_SHADOW_HI, 1'h0, 1'h0, 1'h0, 1'h0);
    chk(exp_q.size(), 16'h0000);
    close_out();
  end
endmodule : testbench
`default_nettype wire
